// >>> src/sar_adc_conversion_control.sv
// conversion sequencing and register file of the successive approximation
// What this block does
// [R01] results right-justified, ten or eight bits
// [R02] round approximation to nearest at resolution
// [R03] full scale gives all ones, zero gives 000
// [R04] divide conversion clock by 1, 2, 4, 8
// [R05] one input at a time, from channel field
// [R06] resolution mode bit picks ten or eight
// [R07] status write starts conversion unless channel off
// [R08] no hardware trigger; software starts only
// [R09] continuous mode restarts after each transfer
// [R10] result load completes conversion, sets flag
// [R11] interrupt if enable high when flag sets
// [R12] ten-bit mode, high read, low unread: transfer blocked, discarded
// [R13] blocked transfer always starts another conversion
// [R14] software avoids reading results mid conversion
// [R15] status write aborts, then maybe restarts
// [R16] clock config write aborts conversion
// [R17] abort on reset or stop without async
// [R18] abort keeps results; reset clears them
// [R19] single mode powers down after each conversion
// [R20] alternate source is four times bus clock
// [R21] channel all ones turns off, isolates pad
// [R22] continuous bit picks continuous or single
//
// The placing of the registers and the APB interface to the registers were decided locally.
`include "sar_adc_map.svh"

module sar_adc_conversion_control
    import sar_adc_pkg::*;
(
    // clock and reset
    input  wire logic         i_clk_sys,
    input  wire logic         i_rst,
    // apb slave
    input  wire apb_req_t     i_apb,
    output logic [31:0]       o_prdata,
    output logic              o_pready,
    output logic              o_pslverr,
    // power management
    input  wire logic         i_stop_mode,
    // analog front end
    input  wire logic         i_cmp_above,
    output analog_out_t       o_analog,
    // completion request
    output logic              o_irq
);

    localparam ctrl_state_t RESET_STATE = '{
        state:   ST_OFF,
        chan:    `CHAN_OFF,
        div_sel: `CLOCK_DIV_RESET,
        res_hi:  `RESULT_HIGH_RESET,
        res_lo:  `RESULT_LOW_RESET,
        aout:    '{channel: `CHAN_OFF, pad_isolate: 1'b1, default: '0},
        default: '0
    };

    ctrl_state_t r_reg;
    ctrl_state_t r_next;
    logic        tick;
    logic        access;
    logic        apb_done;
    logic        wr_status;
    logic        wr_clock;
    logic        converting;
    logic [3:0]  last_bit;
    logic [9:0]  rounded;
    logic        sel_status;
    logic        sel_high;
    logic        sel_low;
    logic        sel_clock;
    logic        rd_done;
    logic        wr_done;
    logic        sample_last;
    logic        blocked;
    logic        stop_abort;
    logic        abort;
    logic [7:0]  status_view;
    logic [7:0]  clock_view;

    // round half up, saturating so full scale stays all ones
    function automatic logic [9:0] round_code(input logic [10:0] a,
                                              input logic        m10);
        logic [10:0] s;
        s = 11'h000;
        if (m10)
        begin
            s = {1'b0, a[10:1]} + {10'h000, a[0]};        // [R02]
            if (s[10])
                s = 11'h3FF;                              // [R03]
        end
        else
        begin
            s = {3'h0, a[10:3]} + {10'h000, a[2]};        // [R02]
            if (s[8])
                s = 11'h0FF;                              // [R03]
        end
        return s[9:0];
    endfunction

    // every state from sampling to transfer keeps the converter powered
    function automatic logic is_powered(input conv_state_t st);
        logic p;
        p = 1'b0;
        case (st)
            ST_SAMPLE,
            ST_TRIAL,
            ST_DECIDE,
            ST_TRANSFER:
                p = 1'b1;
            default:
                p = 1'b0;
        endcase
        return p;
    endfunction

    assign access      = i_apb.psel & i_apb.penable;
    assign apb_done    = access & r_reg.pready;
    assign rd_done     = apb_done & ~i_apb.pwrite;
    assign wr_done     = apb_done & i_apb.pwrite;
    assign sel_status  = (i_apb.paddr == `STATUS_CONTROL_OFFSET);
    assign sel_high    = (i_apb.paddr == `RESULT_HIGH_OFFSET);
    assign sel_low     = (i_apb.paddr == `RESULT_LOW_OFFSET);
    assign sel_clock   = (i_apb.paddr == `CLOCK_CONFIG_OFFSET);
    assign wr_status   = wr_done & sel_status;
    assign wr_clock    = wr_done & sel_clock;
    assign status_view = {r_reg.flag, r_reg.ien, r_reg.cont, r_reg.chan};
    assign clock_view  = {3'h0, r_reg.async_en, r_reg.mode10,
                          r_reg.src_quad, r_reg.div_sel};
    assign converting  = is_powered(r_reg.state);
    assign sample_last = tick & (r_reg.cnt == 4'(`SAMPLE_TICKS - 4'h1));
    // a split ten-bit read still in progress holds the result off
    assign blocked     = r_reg.mode10 & r_reg.hi_pending;            // [R12]
    // stop without the async clock loses the conversion clock
    assign stop_abort  = i_stop_mode & ~r_reg.async_en & converting;  // [R17]
    assign abort       = wr_status | wr_clock | stop_abort;

    conv_clock_divider u_div (
        .i_clk_sys  (i_clk_sys),
        .i_rst      (i_rst),
        .i_restart  (wr_clock),
        .i_src_quad (r_reg.src_quad),                     // [R20]
        .i_div_sel  (r_reg.div_sel),                      // [R04]
        .o_tick     (tick)
    );

    always_comb
    begin
        r_next     = r_reg;
        last_bit   = r_reg.mode10 ? `LAST_BIT_10 : `LAST_BIT_8;   // [R06]
        rounded    = round_code(r_reg.approx, r_reg.mode10);

        // comparator crosses from the analog side
        r_next.cmp_meta = i_cmp_above;
        r_next.cmp_sync = r_reg.cmp_meta;

        // one wait state: answer is registered in the first access cycle
        r_next.pready = 1'b0;
        if (access && !r_reg.pready)
        begin
            r_next.pready  = 1'b1;
            r_next.pslverr = 1'b0;
            r_next.prdata  = 8'h00;
            if (sel_status)
                r_next.prdata = status_view;
            else if (sel_high)
                r_next.prdata = {6'h00, r_reg.res_hi};    // [R01]
            else if (sel_low)
                r_next.prdata = r_reg.res_lo;             // [R01]
            else if (sel_clock)
                r_next.prdata = clock_view;
            else
                r_next.pslverr = 1'b1;
        end

        // conversion engine, stepped by the divided tick
        case (r_reg.state)
            ST_SAMPLE:
            begin
                r_next.aout.sample_en = 1'b1;
                if (tick)
                begin
                    if (sample_last)
                    begin
                        r_next.aout.sample_en = 1'b0;
                        r_next.approx         = 11'h000;
                        r_next.bit_idx        = `MSB_BIT;
                        r_next.state          = ST_TRIAL;
                    end
                    else
                    begin
                        r_next.cnt = 4'(r_reg.cnt + 4'h1);
                    end
                end
            end
            ST_TRIAL:
            begin
                r_next.aout.dac_code = r_reg.approx
                                       | (11'h001 << r_reg.bit_idx);
                // comparator needs its synchroniser delay to settle
                r_next.settle        = `SETTLE_CYCLES;
                r_next.state         = ST_DECIDE;
            end
            ST_DECIDE:
            begin
                if (r_reg.settle != 2'h0)
                begin
                    r_next.settle = 2'(r_reg.settle - 2'h1);
                end
                else if (tick)
                begin
                    if (r_reg.cmp_sync)
                        r_next.approx = r_reg.aout.dac_code;
                    if (r_reg.bit_idx == last_bit)        // [R06]
                    begin
                        r_next.aout.dac_code = 11'h000;
                        r_next.state         = ST_TRANSFER;
                    end
                    else
                    begin
                        r_next.bit_idx = 4'(r_reg.bit_idx - 4'h1);
                        r_next.state   = ST_TRIAL;
                    end
                end
            end
            ST_TRANSFER:
            begin
                r_next.cnt = 4'h0;
                if (blocked)                              // [R12]
                begin
                    // result dropped, flag untouched
                    r_next.state = ST_SAMPLE;             // [R13]
                end
                else
                begin
                    r_next.res_hi = r_reg.mode10 ? rounded[9:8]
                                                 : 2'h0;  // [R01]
                    r_next.res_lo = rounded[7:0];         // [R01]
                    r_next.flag   = 1'b1;                 // [R10]
                    if (r_reg.ien)
                        r_next.irq = 1'b1;                // [R11]
                    if (r_reg.cont)
                        r_next.state = ST_SAMPLE;         // [R09] [R22]
                    else
                        r_next.state = ST_IDLE;           // [R19] [R22]
                end
            end
            default:
            begin
                // off and idle hold; starts come from software only
                r_next.aout.sample_en = 1'b0;             // [R08]
            end
        endcase

        // read guard tracks a split read of a ten-bit result
        if (rd_done)
        begin
            if (sel_high && r_reg.mode10)
                r_next.hi_pending = 1'b1;                 // [R12]
            else if (sel_low)
                r_next.hi_pending = 1'b0;                 // [R12]
        end

        if (stop_abort)
        begin
            r_next.state          = ST_IDLE;              // [R17]
            r_next.aout.sample_en = 1'b0;
            r_next.aout.dac_code  = 11'h000;
        end

        // an abort in the transfer cycle drops that result as well
        if (abort)
        begin
            r_next.res_hi = r_reg.res_hi;                 // [R18]
            r_next.res_lo = r_reg.res_lo;                 // [R18]
            r_next.flag   = r_reg.flag;
            r_next.irq    = r_reg.irq;
        end

        if (wr_clock)
        begin
            r_next.div_sel  = i_apb.pwdata[`CK_DIV_MSB:`CK_DIV_LSB];
            r_next.src_quad = i_apb.pwdata[`CK_QUAD_BIT];
            r_next.mode10   = i_apb.pwdata[`CK_MODE10_BIT];
            r_next.async_en = i_apb.pwdata[`CK_ASYNC_BIT];
            // results stay as last transferred
            r_next.state    = (r_reg.chan == `CHAN_OFF) ? ST_OFF
                                                        : ST_IDLE; // [R16]
            r_next.aout.sample_en = 1'b0;                 // [R18]
            r_next.aout.dac_code  = 11'h000;
        end

        if (wr_status)
        begin
            r_next.chan = i_apb.pwdata[`ST_CHAN_MSB:`ST_CHAN_LSB]; // [R05]
            r_next.cont = i_apb.pwdata[`ST_CONT_BIT];     // [R22]
            r_next.ien  = i_apb.pwdata[`ST_IEN_BIT];
            r_next.flag = 1'b0;
            r_next.irq  = 1'b0;
            r_next.cnt  = 4'h0;
            r_next.aout.sample_en = 1'b0;                 // [R15] [R18]
            r_next.aout.dac_code  = 11'h000;
            if (i_apb.pwdata[`ST_CHAN_MSB:`ST_CHAN_LSB] == `CHAN_OFF)
                r_next.state = ST_OFF;                    // [R21]
            else
                r_next.state = ST_SAMPLE;                 // [R07] [R15]
        end

        // analog side follows the next state so it is never a cycle late
        r_next.aout.channel     = r_next.chan;            // [R05]
        r_next.aout.pad_isolate = (r_next.chan == `CHAN_OFF); // [R21]
        r_next.aout.power_on    = is_powered(r_next.state); // [R19]
    end

    // reset returns results to their reset values
    always_ff @(posedge i_clk_sys or posedge i_rst)
    begin
        if (i_rst)
            r_reg <= RESET_STATE;                         // [R17] [R18]
        else
            r_reg <= r_next;
    end

    assign o_prdata  = {24'h000000, r_reg.prdata};
    assign o_pready  = r_reg.pready;
    assign o_pslverr = r_reg.pslverr;
    assign o_analog  = r_reg.aout;
    assign o_irq     = r_reg.irq;

endmodule // sar_adc_conversion_control

// >>> src/sar_adc_map.svh
// register offsets, field positions, reset values and timing counts
`ifndef SAR_ADC_MAP_SVH
`define SAR_ADC_MAP_SVH

// byte offsets on the register bus
`define STATUS_CONTROL_OFFSET 12'h000
`define RESULT_HIGH_OFFSET    12'h004
`define RESULT_LOW_OFFSET     12'h008
`define CLOCK_CONFIG_OFFSET   12'h00C

// status and control fields
`define ST_CHAN_LSB           0
`define ST_CHAN_MSB           4
`define ST_CONT_BIT           5
`define ST_IEN_BIT            6
`define ST_FLAG_BIT           7

// clock configuration fields
`define CK_DIV_LSB            0
`define CK_DIV_MSB            1
`define CK_QUAD_BIT           2
`define CK_MODE10_BIT         3
`define CK_ASYNC_BIT          4

// reset values
`define CHAN_OFF              5'h1F
`define RESULT_HIGH_RESET     2'h0
`define RESULT_LOW_RESET      8'h00
`define CLOCK_DIV_RESET       2'h0

// conversion sequencing
`define SAMPLE_TICKS          4'h4
`define SETTLE_CYCLES         2'h3
`define MSB_BIT               4'hA
`define LAST_BIT_10           4'h0
`define LAST_BIT_8            4'h2
`define BUS_CLK_RATIO         2'h3

`endif

// >>> src/sar_adc_pkg.sv
// types shared by the conversion control and its clock divider
package sar_adc_pkg;

    typedef enum logic [2:0] {
        ST_OFF,
        ST_IDLE,
        ST_SAMPLE,
        ST_TRIAL,
        ST_DECIDE,
        ST_TRANSFER
    } conv_state_t;

    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [11:0] paddr;
        logic [31:0] pwdata;
    } apb_req_t;

    typedef struct packed {
        logic [10:0] dac_code;
        logic        sample_en;
        logic [4:0]  channel;
        logic        power_on;
        logic        pad_isolate;
    } analog_out_t;

    typedef struct packed {
        conv_state_t state;
        logic [4:0]  chan;
        logic        cont;
        logic        ien;
        logic        flag;
        logic        irq;
        logic [1:0]  div_sel;
        logic        src_quad;
        logic        mode10;
        logic        async_en;
        logic [1:0]  res_hi;
        logic [7:0]  res_lo;
        logic        hi_pending;
        logic [10:0] approx;
        logic [3:0]  bit_idx;
        logic [3:0]  cnt;
        logic [1:0]  settle;
        logic        cmp_meta;
        logic        cmp_sync;
        logic        pready;
        logic        pslverr;
        logic [7:0]  prdata;
        analog_out_t aout;
    } ctrl_state_t;

    typedef struct packed {
        logic [1:0] pre;
        logic [2:0] div;
        logic       tick;
    } div_state_t;

endpackage

// >>> src/conv_clock_divider.sv
// conversion clock tick generator: source select and divide by 1/2/4/8
`include "sar_adc_map.svh"

module conv_clock_divider
    import sar_adc_pkg::*;
(
    // clock and reset
    input  wire logic       i_clk_sys,
    input  wire logic       i_rst,
    // configuration
    input  wire logic       i_restart,
    input  wire logic       i_src_quad,
    input  wire logic [1:0] i_div_sel,
    // tick out
    output logic            o_tick
);

    div_state_t r_reg;
    div_state_t r_next;
    logic       src_tick;
    logic [2:0] div_limit;

    always_comb
    begin
        r_next    = r_reg;
        div_limit = 3'((4'h1 << i_div_sel) - 4'h1);
        // system clock is four bus clocks; bus clock is one in four
        src_tick  = i_src_quad | (r_reg.pre == `BUS_CLK_RATIO);
        r_next.pre  = 2'(r_reg.pre + 2'h1);
        r_next.tick = 1'b0;
        if (src_tick)
        begin
            if (r_reg.div >= div_limit)
            begin
                r_next.div  = 3'h0;
                r_next.tick = 1'b1;
            end
            else
            begin
                r_next.div = 3'(r_reg.div + 3'h1);
            end
        end
        // restart keeps the first tick a full period away
        if (i_restart)
        begin
            r_next = '0;
        end
    end

    always_ff @(posedge i_clk_sys or posedge i_rst)
    begin
        if (i_rst)
            r_reg <= '0;
        else
            r_reg <= r_next;
    end

    assign o_tick = r_reg.tick;

endmodule // conv_clock_divider

// >>> dv/sar_adc_properties.sv
// port checks for the conversion control, bound to its top
`include "sar_adc_map.svh"

module sar_adc_properties
    import sar_adc_pkg::*;
(
    // watched ports
    input  wire logic        i_clk_sys,
    input  wire logic        i_rst,
    input  wire apb_req_t    i_apb,
    input  wire logic [31:0] o_prdata,
    input  wire logic        o_pready,
    input  wire logic        o_pslverr,
    input  wire logic        i_stop_mode,
    input  wire logic        i_cmp_above,
    input  wire analog_out_t o_analog,
    input  wire logic        o_irq
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (i_rst);
    logic acc;
    logic map;
    logic wr_st;
    assign acc = i_apb.psel && i_apb.penable && o_pready;
    assign map = i_apb.paddr inside {`STATUS_CONTROL_OFFSET,
        `RESULT_HIGH_OFFSET, `RESULT_LOW_OFFSET, `CLOCK_CONFIG_OFFSET};
    assign wr_st = acc && i_apb.pwrite
        && i_apb.paddr == `STATUS_CONTROL_OFFSET;

    chk_bus_wait: assert property (
        $rose(i_apb.penable) && i_apb.psel |-> !o_pready ##1 o_pready)
        else $error("pready not in second access cycle");
    chk_ready_pulse: assert property (
        o_pready |=> !o_pready)
        else $error("pready longer than one cycle");
    chk_bad_addr: assert property (
        acc && !map |-> o_pslverr && o_prdata == 32'h0)
        else $error("unmapped access not refused");
    chk_good_addr: assert property (
        acc && map |-> !o_pslverr && o_prdata[31:8] == 24'h0)
        else $error("mapped access with error or wide data");
    chk_off_isolate: assert property (
        o_analog.pad_isolate == (o_analog.channel == `CHAN_OFF))
        else $error("pad isolation does not follow channel off");
    chk_off_power: assert property (
        o_analog.pad_isolate |-> !o_analog.power_on)
        else $error("converter powered while isolated");
    chk_idle_dac: assert property (
        !o_analog.power_on |-> o_analog.dac_code == 11'h0)
        else $error("dac code while powered down");
    chk_sample_dac: assert property (
        o_analog.sample_en |-> o_analog.power_on && !o_analog.dac_code)
        else $error("sampling without power or with trial code");
    chk_irq_clear: assert property (
        wr_st |=> !o_irq)
        else $error("irq survives status write");
    chk_start_sample: assert property (
        wr_st && i_apb.pwdata[4:0] != `CHAN_OFF |-> ##[1:3]
        o_analog.sample_en)
        else $error("status write did not start sampling");

    cover property ($rose(o_irq));
    cover property (acc && o_pslverr);
    cover property ($fell(o_analog.sample_en));
endmodule // sar_adc_properties

bind sar_adc_conversion_control sar_adc_properties u_props (
    .i_clk_sys   (i_clk_sys),
    .i_rst       (i_rst),
    .i_apb       (i_apb),
    .o_prdata    (o_prdata),
    .o_pready    (o_pready),
    .o_pslverr   (o_pslverr),
    .i_stop_mode (i_stop_mode),
    .i_cmp_above (i_cmp_above),
    .o_analog    (o_analog),
    .o_irq       (o_irq)
);

// >>> dv/analog_frontend_model.sv
// analog inputs and comparator facing the converter
module analog_frontend_model
    import sar_adc_pkg::*;
(
    // clock
    input  wire logic        i_clk_sys,
    // from the converter and the bench
    input  wire analog_out_t i_analog,
    input  wire logic [4:0]  i_chan,
    input  wire logic [10:0] i_level,
    // comparator
    output logic             o_cmp_above
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [10:0] vin;
    logic        junk = 1'b0;
    // other inputs carry the inverse, so a wrong mux shows
    assign vin = (i_analog.channel == i_chan) ? i_level : ~i_level;
    always @(posedge i_clk_sys) junk <= ~junk;
    // unpowered comparator toggles rather than hold a level
    assign o_cmp_above = i_analog.power_on
        ? (vin >= i_analog.dac_code) : junk;
endmodule // analog_frontend_model

// >>> dv/sar_adc_conversion_control_test.sv
// register level tests of the conversion control
`include "sar_adc_map.svh"

module sar_adc_conversion_control_test
    import sar_adc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic        i_clk_sys = 1'b0;
    logic        i_rst = 1'b1;
    apb_req_t    apb = '0;
    logic        stop = 1'b0;
    logic [10:0] level = 11'h0;
    logic [31:0] prdata;
    logic        pready, pslverr, cmp, irq, err;
    analog_out_t aout;
    logic [31:0] q;
    int          n_fail = 0, n_compared = 0, win = 0, cur = 0, p;
    logic [7:0]  cfgs [7] = '{8'h0C, 8'h0D, 8'h0E, 8'h0F, 8'h04, 8'h04, 8'h08};
    logic [10:0] lvls [7] = '{11'h155, 11'h7FF, 11'h0, 11'h2AA, 11'h7FF,
                              11'h25A, 11'h3FE};

    sar_adc_conversion_control DUT (
        .i_clk_sys   (i_clk_sys),
        .i_rst       (i_rst),
        .i_apb       (apb),
        .o_prdata    (prdata),
        .o_pready    (pready),
        .o_pslverr   (pslverr),
        .i_stop_mode (stop),
        .i_cmp_above (cmp),
        .o_analog    (aout),
        .o_irq       (irq)
    );
    analog_frontend_model u_afe (
        .i_clk_sys   (i_clk_sys),
        .i_analog    (aout),
        .i_chan      (5'h03),
        .i_level     (level),
        .o_cmp_above (cmp)
    );

    initial forever #5 i_clk_sys = ~i_clk_sys;
    // length of the last sampling window
    always @(posedge i_clk_sys)
    begin
        cur <= (aout.sample_en === 1'b1) ? cur + 1 : 0;
        if (aout.sample_en !== 1'b1 && cur != 0)
            win <= cur;
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic bus(input logic wr, input logic [11:0] a,
                       input logic [31:0] d);
        int n;
        n = 0;
        apb <= '{1'b1, 1'b0, wr, a, d};
        @(posedge i_clk_sys);
        apb.penable <= 1'b1;
        do
        begin
            @(posedge i_clk_sys);
            n++;
        end
        while (pready !== 1'b1 && n < 20);
        q = prdata;
        err = pslverr;
        if (n == 20)
            n_fail++;
        apb.psel <= 1'b0;
        apb.penable <= 1'b0;
        @(posedge i_clk_sys);
    endtask
    // polls the flag only, so the read guard is never armed here
    task automatic wait_done(input logic exp);
        int n;
        n = 0;
        do
        begin
            bus(1'b0, `STATUS_CONTROL_OFFSET, 32'h0);
            n++;
        end
        while (q[`ST_FLAG_BIT] !== 1'b1 && n < 100);
        check(32'(q[`ST_FLAG_BIT]), 32'(exp));
    endtask
    task automatic results(input logic [9:0] e);
        bus(1'b0, `RESULT_HIGH_OFFSET, 32'h0);
        check(q, {30'h0, e[9:8]});
        bus(1'b0, `RESULT_LOW_OFFSET, 32'h0);
        check(q, {24'h0, e[7:0]});
    endtask
    task automatic wait_sample();
        int n;
        n = 0;
        while (aout.sample_en !== 1'b1 && n < 300)
        begin
            @(posedge i_clk_sys);
            n++;
        end
        check(32'(n < 300), 32'h1);
    endtask
    function automatic logic [9:0] res(input logic m10, input logic [10:0] v);
        logic [11:0] r;
        r = m10 ? ({1'b0, v} + 12'h1) >> 1 : ({3'h0, v[10:2]} + 12'h1) >> 1;
        if (r > (m10 ? 12'h3FF : 12'h0FF))
            r = m10 ? 12'h3FF : 12'h0FF;
        return r[9:0];
    endfunction
    task automatic convert(input logic [7:0] cfg, input logic [10:0] v);
        level <= v;
        bus(1'b1, `CLOCK_CONFIG_OFFSET, {24'h0, cfg});
        bus(1'b1, `STATUS_CONTROL_OFFSET, 32'h43);
        wait_done(1'b1);
        check(32'(irq), 32'h1);
        check(32'(aout.power_on), 32'h0);
        results(res(cfg[`CK_MODE10_BIT], v));
    endtask
    task automatic summarize();
        $display("counts: compared %0d failed %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    initial
    begin
        #200us;
        n_fail++;
        summarize();
    end
    initial
    begin
        repeat (16) @(posedge i_clk_sys);
        i_rst <= 1'b0;
        @(posedge i_clk_sys);
        for (int i = 0; i < 4; i++)
        begin
            bus(1'b0, 12'(4 * i), 32'h0);
            check(q, (i == 0) ? 32'h1F : 32'h0);
        end
        check(32'(aout.pad_isolate), 32'h1);
        bus(1'b0, 12'h010, 32'h0);
        check({q[30:0], err}, 32'h1);
        $display("reset test done");
        for (int i = 0; i < 7; i++)
        begin
            convert(cfgs[i], lvls[i]);
            p = (cfgs[i][`CK_QUAD_BIT] ? 1 : 4) << cfgs[i][1:0];
            check(32'(win >= 3 * p && win <= 4 * p + 2), 32'h1);
        end
        $display("conversion test done");
        level <= 11'h100;
        bus(1'b1, `CLOCK_CONFIG_OFFSET, 32'h0C);
        bus(1'b1, `STATUS_CONTROL_OFFSET, 32'h43);
        bus(1'b0, `RESULT_HIGH_OFFSET, 32'h0);
        wait_done(1'b0);
        results(res(1'b1, 11'h3FE));
        wait_done(1'b1);
        results(res(1'b1, 11'h100));
        $display("guard test done");
        level <= 11'h200;
        bus(1'b1, `STATUS_CONTROL_OFFSET, 32'h23);
        wait_done(1'b1);
        wait_sample();
        check(32'(aout.power_on), 32'h1);
        $display("continuous test done");
        convert(8'h0C, 11'h200);
        for (int k = 0; k < 3; k++)
        begin
            level <= 11'h7FF;
            bus(1'b1, `STATUS_CONTROL_OFFSET, 32'h03);
            wait_sample();
            if (k == 0)
                bus(1'b1, `STATUS_CONTROL_OFFSET, 32'h1F);
            else if (k == 1)
                bus(1'b1, `CLOCK_CONFIG_OFFSET, 32'h0C);
            else
            begin
                stop <= 1'b1;
                @(posedge i_clk_sys);
                stop <= 1'b0;
            end
            wait_done(1'b0);
            check(32'(irq), 32'h0);
            results(res(1'b1, 11'h200));
        end
        bus(1'b1, `CLOCK_CONFIG_OFFSET, 32'h1C);
        bus(1'b1, `STATUS_CONTROL_OFFSET, 32'h03);
        wait_sample();
        stop <= 1'b1;
        @(posedge i_clk_sys);
        stop <= 1'b0;
        wait_done(1'b1);
        results(res(1'b1, 11'h7FF));
        bus(1'b1, `STATUS_CONTROL_OFFSET, 32'h1F);
        check(32'(aout.pad_isolate), 32'h1);
        check(32'(aout.power_on), 32'h0);
        $display("abort test done");
        summarize();
    end
endmodule // sar_adc_conversion_control_test
